//--- src/mfa_frame_asm.sv
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module mfa_frame_asm (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 meas_valid,
  input  wire logic [mfa_pkg::EXPO_W-1:0] meas_expo,
  input  wire logic [31:0]          meas_ts,
  input  wire logic [mfa_pkg::TEMP_W-1:0] meas_temp,
  input  wire logic [31:0]          meas_int0,
  input  wire logic [31:0]          meas_disp0,
  input  wire logic [31:0]          meas_int1,
  input  wire logic [31:0]          meas_disp1,
  input  wire logic [31:0]          meas_status,
  input  wire logic [31:0]          meas_trig,
  input  wire logic [31:0]          meas_diff,
  input  wire logic [31:0]          meas_min,
  input  wire logic [31:0]          meas_max,
  input  wire logic [31:0]          meas_span,
  output logic [8:0]                vid_addr,
  output logic                      vid_kind,
  input  wire logic [15:0]          vid_data_a,
  input  wire logic [15:0]          vid_data_b,
  output logic                      net_tvalid,
  output logic [7:0]                net_tdata,
  output logic                      net_tlast,
  input  wire logic                 net_tready,
  output logic                      ser_valid,
  output logic [1:0]                ser_count,
  output logic [mfa_pkg::SER_W-1:0] ser_word0,
  output logic [mfa_pkg::SER_W-1:0] ser_word1
);
  import mfa_pkg::*;

  // Register file and bus slave
  logic        awh_r, awh_nxt, wh_r, wh_nxt, awr_r, awr_nxt, wr_r, wr_nxt;
  logic        bv_r, bv_nxt, arr_r, arr_nxt, rv_r, rv_nxt;
  logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
  logic [7:0]  wa_r, wa_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [3:0]  ws_r, ws_nxt;
  logic [3:0]  ctrl_r, ctrl_nxt;
  logic [12:0] sel_r, sel_nxt;
  logic [7:0]  sersel_r, sersel_nxt;
  logic [15:0] drop_r, drop_nxt;
  logic [CNT_W-1:0] cnt;
  mfa_state_t  state_r, state_nxt;
  logic        take;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    awh_nxt = awh_r;
    wh_nxt = wh_r;
    wa_nxt = wa_r;
    wd_nxt = wd_r;
    ws_nxt = ws_r;
    bv_nxt = bv_r;
    br_nxt = br_r;
    rv_nxt = rv_r;
    rr_nxt = rr_r;
    rd_nxt = rd_r;
    ctrl_nxt = ctrl_r;
    sel_nxt = sel_r;
    sersel_nxt = sersel_r;
    drop_nxt = drop_r;
    if (s_axi_awvalid && awr_r) begin
      awh_nxt = 1'b1;
      wa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wr_r) begin
      wh_nxt = 1'b1;
      wd_nxt = s_axi_wdata;
      ws_nxt = s_axi_wstrb;
    end
    if (bv_r && s_axi_bready) begin
      bv_nxt = 1'b0;
    end
    if (awh_r && wh_r && !bv_r) begin
      awh_nxt = 1'b0;
      wh_nxt = 1'b0;
      bv_nxt = 1'b1;
      br_nxt = RESP_OKAY;
      if (wa_r[7:2] == OFS_CTRL[7:2]) begin
        ctrl_nxt = 4'(merge({28'h0, ctrl_r}, wd_r, ws_r));
      end else if (wa_r[7:2] == OFS_SEL[7:2]) begin
        sel_nxt = 13'(merge({19'h0, sel_r}, wd_r, ws_r));
      end else if (wa_r[7:2] == OFS_SERSEL[7:2]) begin
        sersel_nxt = 8'(merge({24'h0, sersel_r}, wd_r, ws_r));
      end else if (wa_r[7:2] != OFS_STAT[7:2]
                   && wa_r[7:2] != OFS_DROP[7:2]) begin
        br_nxt = RESP_SLVERR;
      end
    end
    if (rv_r && s_axi_rready) begin
      rv_nxt = 1'b0;
    end
    if (s_axi_arvalid && arr_r) begin
      rv_nxt = 1'b1;
      rr_nxt = RESP_OKAY;
      rd_nxt = 32'h00000000;
      if (s_axi_araddr[7:2] == OFS_CTRL[7:2]) begin
        rd_nxt = {28'h0, ctrl_r};
      end else if (s_axi_araddr[7:2] == OFS_SEL[7:2]) begin
        rd_nxt = {19'h0, sel_r};
      end else if (s_axi_araddr[7:2] == OFS_SERSEL[7:2]) begin
        rd_nxt = {24'h0, sersel_r};
      end else if (s_axi_araddr[7:2] == OFS_STAT[7:2]) begin
        rd_nxt = {7'h0, state_r != ST_IDLE, cnt};
      end else if (s_axi_araddr[7:2] == OFS_DROP[7:2]) begin
        rd_nxt = {16'h0, drop_r};
      end else begin
        rr_nxt = RESP_SLVERR;
      end
    end
    // Frame still on the wire: the new cycle is lost and counted
    if (meas_valid && !take && drop_r != 16'hFFFF) begin
      drop_nxt = drop_r + 16'h0001;
    end
    awr_nxt = !awh_nxt;
    wr_nxt = !wh_nxt;
    arr_nxt = !rv_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awh_r <= 1'b0;
      wh_r <= 1'b0;
      awr_r <= 1'b0;
      wr_r <= 1'b0;
      arr_r <= 1'b0;
      wa_r <= 8'h00;
      wd_r <= 32'h00000000;
      ws_r <= 4'h0;
      bv_r <= 1'b0;
      br_r <= RESP_OKAY;
      rv_r <= 1'b0;
      rr_r <= RESP_OKAY;
      rd_r <= 32'h00000000;
      ctrl_r <= CTRL_RST;
      sel_r <= SEL_RST;
      sersel_r <= SERSEL_RST;
      drop_r <= 16'h0000;
    end else begin
      awh_r <= awh_nxt;
      wh_r <= wh_nxt;
      awr_r <= awr_nxt;
      wr_r <= wr_nxt;
      arr_r <= arr_nxt;
      wa_r <= wa_nxt;
      wd_r <= wd_nxt;
      ws_r <= ws_nxt;
      bv_r <= bv_nxt;
      br_r <= br_nxt;
      rv_r <= rv_nxt;
      rr_r <= rr_nxt;
      rd_r <= rd_nxt;
      ctrl_r <= ctrl_nxt;
      sel_r <= sel_nxt;
      sersel_r <= sersel_nxt;
      drop_r <= drop_nxt;
    end
  end

  assign s_axi_awready = awr_r;
  assign s_axi_wready = wr_r;
  assign s_axi_bvalid = bv_r;
  assign s_axi_bresp = br_r;
  assign s_axi_arready = arr_r;
  assign s_axi_rvalid = rv_r;
  assign s_axi_rresp = rr_r;
  assign s_axi_rdata = rd_r;
  assign vid_kind = ctrl_r[CTRL_VKIND];

  // Frame sequencer
  logic [31:0] snap_r [NFLD];
  logic [31:0] snap_nxt [NFLD];
  logic [31:0] snap_in [NFLD];
  logic [3:0]  fidx_r, fidx_nxt, lastf_r, lastf_nxt;
  logic [8:0]  pix_r, pix_nxt;
  logic        ch_r, ch_nxt, seen_r, seen_nxt;
  logic        ld, ld_two, ld_last, bs_idle;
  logic [31:0] ld_word;
  logic [NFLD-1:0] fsel, later;
  logic        thick, inten, va, vb;
  logic        sv_r, sv_nxt;
  logic [1:0]  sc_r, sc_nxt;
  logic [SER_W-1:0] sw_r [2];
  logic [SER_W-1:0] sw_nxt [2];

  assign thick = ctrl_r[CTRL_THICK];
  assign inten = ctrl_r[CTRL_INTEN];
  assign va = sel_r[SEL_VID_A];
  assign vb = sel_r[SEL_VID_B];
  assign take = state_r == ST_IDLE && meas_valid;

  always_comb begin
    snap_in[FI_EXPO] = {15'h0, meas_expo};
    snap_in[FI_CNT] = {8'h00, cnt};
    snap_in[FI_TS] = meas_ts;
    snap_in[FI_TEMP] = {{22{meas_temp[TEMP_W-1]}}, meas_temp};
    snap_in[FI_INT0] = meas_int0;
    snap_in[FI_DISP0] = meas_disp0;
    snap_in[FI_INT1] = meas_int1;
    snap_in[FI_DISP1] = meas_disp1;
    snap_in[FI_STAT] = meas_status;
    snap_in[FI_TRIG] = meas_trig;
    snap_in[FI_DIFF] = meas_diff;
    snap_in[FI_MIN] = meas_min;
    snap_in[FI_MAX] = meas_max;
    snap_in[FI_SPAN] = meas_span;
  end

  always_comb begin
    fsel = '0;
    fsel[FI_EXPO] = sel_r[SEL_EXPO];
    fsel[FI_CNT] = sel_r[SEL_CNT];
    fsel[FI_TS] = sel_r[SEL_TS];
    fsel[FI_TEMP] = sel_r[SEL_TEMP];
    fsel[FI_INT0] = sel_r[SEL_DISP] && inten;
    fsel[FI_DISP0] = sel_r[SEL_DISP];
    fsel[FI_INT1] = sel_r[SEL_DISP] && inten && thick;
    fsel[FI_DISP1] = sel_r[SEL_DISP] && thick;
    fsel[FI_STAT] = sel_r[SEL_STAT];
    fsel[FI_TRIG] = sel_r[SEL_TRIG];
    fsel[FI_DIFF] = sel_r[SEL_DIFF] && thick;
    fsel[FI_MIN] = sel_r[SEL_MIN];
    fsel[FI_MAX] = sel_r[SEL_MAX];
    fsel[FI_SPAN] = sel_r[SEL_SPAN];
    later = (fsel >> fidx_r) >> 1;
  end

  always_comb begin
    state_nxt = state_r;
    fidx_nxt = fidx_r;
    pix_nxt = pix_r;
    ch_nxt = ch_r;
    snap_nxt = snap_r;
    lastf_nxt = lastf_r;
    seen_nxt = seen_r;
    ld = 1'b0;
    ld_two = 1'b0;
    ld_last = 1'b0;
    ld_word = 32'h00000000;
    case (state_r)
      ST_IDLE: begin
        if (meas_valid) begin
          snap_nxt = snap_in;
          fidx_nxt = FI_EXPO;
          pix_nxt = 9'h000;
          seen_nxt = 1'b0;
          if (!ctrl_r[CTRL_PORT]) begin
            state_nxt = (va || vb) ? ST_VADDR : ST_FLD;
          end
        end
      end
      ST_VADDR: begin
        ch_nxt = !va;
        state_nxt = ST_VID;
      end
      ST_VID: begin
        if (bs_idle) begin
          ld = 1'b1;
          ld_two = 1'b1;
          ld_word = {16'h0000, ch_r ? vid_data_b : vid_data_a};
          ld_last = pix_r == PIX_LAST && (ch_r || !vb) && fsel == '0;
          if (!ch_r && vb) begin
            ch_nxt = 1'b1;
          end else if (pix_r == PIX_LAST) begin
            state_nxt = ST_FLD;
          end else begin
            pix_nxt = pix_r + 9'h001;
            state_nxt = ST_VADDR;
          end
        end
      end
      ST_FLD: begin
        if (fsel[fidx_r]) begin
          ld = bs_idle;
          ld_word = snap_r[fidx_r];
          ld_last = later == '0;
        end
        if (ld) begin
          lastf_nxt = fidx_r;
          seen_nxt = 1'b1;
        end
        if (!fsel[fidx_r] || bs_idle) begin
          if (fidx_r == FI_SPAN) begin
            state_nxt = ST_IDLE;
          end else begin
            fidx_nxt = fidx_r + 4'h1;
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_comb begin
    logic [3:0] code;
    code = 4'h0;
    sv_nxt = take && ctrl_r[CTRL_PORT];
    sc_nxt = sv_nxt ? 2'h0 : sc_r;
    sw_nxt = sw_r;
    for (int k = 0; k < 2; k++) begin
      code = sersel_r[4*k +: 4];
      if (sv_nxt) begin
        sw_nxt[k] = '0;
        if (code == SC_EXPO) begin
          sw_nxt[k] = {1'b0, meas_expo};
        end else if (code == SC_CNT) begin
          sw_nxt[k] = cnt[SER_W-1:0];
        end else if (code == SC_TS) begin
          sw_nxt[k] = meas_ts[TS_SER_LO +: SER_W];
        end else if (code == SC_DISP0) begin
          sw_nxt[k] = meas_disp0[SER_W-1:0];
        end else if (code == SC_DISP1) begin
          sw_nxt[k] = meas_disp1[SER_W-1:0];
        end else if (code == SC_INT0) begin
          sw_nxt[k] = {8'h00, meas_int0[INT_SER_W-1:0]};
        end else if (code == SC_STAT) begin
          sw_nxt[k] = meas_status[SER_W-1:0];
        end
        if (code != 4'h0) begin
          sc_nxt = sc_nxt + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      fidx_r <= FI_EXPO;
      pix_r <= 9'h000;
      ch_r <= 1'b0;
      lastf_r <= FI_EXPO;
      seen_r <= 1'b0;
      sv_r <= 1'b0;
      sc_r <= 2'h0;
      for (int k = 0; k < 2; k++) begin
        sw_r[k] <= '0;
      end
      for (int f = 0; f < NFLD; f++) begin
        snap_r[f] <= 32'h00000000;
      end
    end else begin
      state_r <= state_nxt;
      fidx_r <= fidx_nxt;
      pix_r <= pix_nxt;
      ch_r <= ch_nxt;
      lastf_r <= lastf_nxt;
      seen_r <= seen_nxt;
      sv_r <= sv_nxt;
      sc_r <= sc_nxt;
      sw_r <= sw_nxt;
      snap_r <= snap_nxt;
    end
  end

  assign vid_addr = pix_r;
  assign ser_valid = sv_r;
  assign ser_count = sc_r;
  assign ser_word0 = sw_r[0];
  assign ser_word1 = sw_r[1];

  // counter advances on each taken cycle
  mfa_meas_cnt u_cnt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .inc     (take),
    .count   (cnt)
  );

  mfa_byte_ser u_ser (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ld      (ld),
    .ld_word (ld_word),
    .ld_two  (ld_two),
    .ld_last (ld_last),
    .idle    (bs_idle),
    .tvalid  (net_tvalid),
    .tdata   (net_tdata),
    .tlast   (net_tlast),
    .tready  (net_tready)
  );

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_fld_ld(logic [3:0] f);
    ld && state_r == ST_FLD && fidx_r == f;
  endsequence
  a_expo_rsvd_zero: assert property (
    s_fld_ld(FI_EXPO) |-> ld_word[31:17] == 15'h0000)
    else $error("exposure reserved bits set");
  a_cnt_rsvd_zero: assert property (
    s_fld_ld(FI_CNT) |-> ld_word[31:24] == 8'h00)
    else $error("counter reserved bits set");
  a_int_gated_off: assert property (
    s_fld_ld(FI_INT0) or s_fld_ld(FI_INT1) |-> inten)
    else $error("intensity sent while disabled");
  a_diff_thick_only: assert property (
    s_fld_ld(FI_DIFF) or s_fld_ld(FI_DISP1) |-> thick)
    else $error("second peak or difference outside thickness mode");
  a_fld_order_up: assert property (
    ld && state_r == ST_FLD && seen_r |-> fidx_r > lastf_r)
    else $error("frame fields out of order");
  a_int_ahead_disp: assert property (
    ld && state_r == ST_FLD && fidx_r == FI_DISP0 && inten |->
      seen_r && lastf_r == FI_INT0)
    else $error("intensity not ahead of displacement");
  a_vid_pix_pair: assert property (
    ld && state_r == ST_VID && !ch_r && vb |=>
      state_r == ST_VID && ch_r && pix_r == $past(pix_r))
    else $error("pixel samples not back to back");
  a_ser_expo_cut: assert property (
    take && ctrl_r[CTRL_PORT] && sersel_r[3:0] == SC_EXPO |=>
      ser_word0 == {1'b0, $past(meas_expo)})
    else $error("serial exposure not cut to 17 bits");
  a_ser_cnt_cut: assert property (
    take && ctrl_r[CTRL_PORT] && sersel_r[3:0] == SC_CNT |=>
      ser_word0 == $past(cnt[17:0]))
    else $error("serial counter not cut to 18 bits");
  a_ser_ts_cut: assert property (
    take && ctrl_r[CTRL_PORT] && sersel_r[7:4] == SC_TS |=>
      ser_word1 == $past(meas_ts[25:8]))
    else $error("serial time stamp bits wrong");
  a_port_one_way: assert property (
    take && ctrl_r[CTRL_PORT] |=> ser_valid && state_r == ST_IDLE)
    else $error("measurement sent on both ports");
endmodule

//--- src/mfa_pkg.sv
// Summary of operation
// - All values of one measurement cycle go out as one network frame.
// - Fields follow a fixed order; every non-video field is one 32-bit word.
// - Video gives 512 16-bit pixels; selected signals interleave per pixel.
// - One or two displacements; thickness mode adds one difference word.
// - Intensity words are sent only while intensity output is enabled; serial code SC_INT0 ignores CTRL_INTEN.
// - Unselected fields are omitted, so frame layout follows the selection.
// - Each peak's intensity word comes right before its displacement word.
// - Exposure word holds 17 bits in 12.5 ns steps; bits 31..17 read zero.
// - With exposure selected, every displacement result carries an exposure word; serial words follow SERSEL and ignore SEL_EXPO.
// - The serial port sends only the 17 low exposure bits.
// - Measured value counter is 24 bits; its upper eight bits are zero.
// - The serial port sends only 18 counter bits, wrapping after 262143.
// - Video and values of one frame carry the same counter value.
// - Serial port never sends video and at most two binary values.
// - Measurement data goes to network or serial port, never both.
// - Video pairs are raw plus filtered, or two raw signals.
// - Time stamp is 32 bits in 1 us; serial carries bits 25..8.
package mfa_pkg;
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SEL    = 8'h04;
  localparam logic [7:0] OFS_SERSEL = 8'h08;
  localparam logic [7:0] OFS_STAT   = 8'h0C;
  localparam logic [7:0] OFS_DROP   = 8'h10;
  localparam int CTRL_PORT  = 0;
  localparam int CTRL_THICK = 1;
  localparam int CTRL_INTEN = 2;
  localparam int CTRL_VKIND = 3;
  localparam int SEL_VID_A  = 0;
  localparam int SEL_VID_B  = 1;
  localparam int SEL_EXPO   = 2;
  localparam int SEL_CNT    = 3;
  localparam int SEL_TS     = 4;
  localparam int SEL_TEMP   = 5;
  localparam int SEL_DISP   = 6;
  localparam int SEL_STAT   = 7;
  localparam int SEL_TRIG   = 8;
  localparam int SEL_DIFF   = 9;
  localparam int SEL_MIN    = 10;
  localparam int SEL_MAX    = 11;
  localparam int SEL_SPAN   = 12;
  localparam int STAT_BUSY  = 24;
  localparam logic [3:0]  CTRL_RST   = 4'h0;
  localparam logic [12:0] SEL_RST    = 13'h004C;
  localparam logic [7:0]  SERSEL_RST = 8'h04;
  localparam int          NFLD       = 14;
  localparam logic [3:0]  FI_EXPO  = 4'h0;
  localparam logic [3:0]  FI_CNT   = 4'h1;
  localparam logic [3:0]  FI_TS    = 4'h2;
  localparam logic [3:0]  FI_TEMP  = 4'h3;
  localparam logic [3:0]  FI_INT0  = 4'h4;
  localparam logic [3:0]  FI_DISP0 = 4'h5;
  localparam logic [3:0]  FI_INT1  = 4'h6;
  localparam logic [3:0]  FI_DISP1 = 4'h7;
  localparam logic [3:0]  FI_STAT  = 4'h8;
  localparam logic [3:0]  FI_TRIG  = 4'h9;
  localparam logic [3:0]  FI_DIFF  = 4'hA;
  localparam logic [3:0]  FI_MIN   = 4'hB;
  localparam logic [3:0]  FI_MAX   = 4'hC;
  localparam logic [3:0]  FI_SPAN  = 4'hD;
  localparam logic [8:0]  PIX_LAST = 9'h1FF;
  localparam int EXPO_W = 17;
  localparam int CNT_W  = 24;
  localparam int SER_W  = 18;
  localparam int TEMP_W = 10;
  localparam int TS_SER_LO = 8;
  localparam int INT_SER_W = 10;
  localparam logic [3:0] SC_EXPO  = 4'h1;
  localparam logic [3:0] SC_CNT   = 4'h2;
  localparam logic [3:0] SC_TS    = 4'h3;
  localparam logic [3:0] SC_DISP0 = 4'h4;
  localparam logic [3:0] SC_DISP1 = 4'h5;
  localparam logic [3:0] SC_INT0  = 4'h6;
  localparam logic [3:0] SC_STAT  = 4'h7;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_VADDR = 2'b01,
    ST_VID   = 2'b10,
    ST_FLD   = 2'b11
  } mfa_state_t;
endpackage

//--- src/mfa_meas_cnt.sv
`timescale 1ns/1ps
module mfa_meas_cnt (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      inc,
  output logic [mfa_pkg::CNT_W-1:0]      count
);
  import mfa_pkg::*;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (inc) begin
      cnt_nxt = cnt_r + 24'h000001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign count = cnt_r;

  a_cnt_wrap_step: assert property (@(posedge aclk) disable iff (!aresetn)
    inc |=> cnt_r == 24'($past(cnt_r) + 24'h000001))
    else $error("measurement counter did not step by one");
endmodule

//--- src/mfa_byte_ser.sv
`timescale 1ns/1ps
module mfa_byte_ser (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ld,
  input  wire logic [31:0] ld_word,
  input  wire logic        ld_two,
  input  wire logic        ld_last,
  output logic             idle,
  output logic             tvalid,
  output logic [7:0]       tdata,
  output logic             tlast,
  input  wire logic        tready
);
  logic        tv_r, tv_nxt, tl_r, tl_nxt, fl_r, fl_nxt;
  logic [7:0]  td_r, td_nxt;
  logic [23:0] sh_r, sh_nxt;
  logic [1:0]  left_r, left_nxt;

  always_comb begin
    tv_nxt = tv_r;
    td_nxt = td_r;
    tl_nxt = tl_r;
    fl_nxt = fl_r;
    sh_nxt = sh_r;
    left_nxt = left_r;
    if (!tv_r && ld) begin
      tv_nxt = 1'b1;
      td_nxt = ld_word[7:0];
      sh_nxt = ld_word[31:8];
      left_nxt = ld_two ? 2'h1 : 2'h3;
      fl_nxt = ld_last;
      tl_nxt = ld_last && ld_two ? 1'b0 : 1'b0;
    end else if (tv_r && tready) begin
      if (left_r == 2'h0) begin
        tv_nxt = 1'b0;
        tl_nxt = 1'b0;
      end else begin
        td_nxt = sh_r[7:0];
        sh_nxt = {8'h00, sh_r[23:8]};
        left_nxt = left_r - 2'h1;
        tl_nxt = fl_r && (left_r == 2'h1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tv_r <= 1'b0;
      td_r <= 8'h00;
      tl_r <= 1'b0;
      fl_r <= 1'b0;
      sh_r <= 24'h000000;
      left_r <= 2'h0;
    end else begin
      tv_r <= tv_nxt;
      td_r <= td_nxt;
      tl_r <= tl_nxt;
      fl_r <= fl_nxt;
      sh_r <= sh_nxt;
      left_r <= left_nxt;
    end
  end

  assign idle = !tv_r;
  assign tvalid = tv_r;
  assign tdata = td_r;
  assign tlast = tl_r;

  sequence s_word_load;
    !tv_r && ld && !ld_two;
  endsequence
  a_lsb_first_out: assert property (@(posedge aclk) disable iff (!aresetn)
    s_word_load |=> tv_r && td_r == $past(ld_word[7:0])
      && sh_r[7:0] == $past(ld_word[15:8]))
    else $error("byte order not least significant first");
endmodule

//--- sim/mfa_host_model.sv
`timescale 1ns/1ps
module mfa_host_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       tvalid,
  input  wire logic [7:0] tdata,
  input  wire logic       tlast,
  output logic            tready
);
  logic [8:0] q[$];
  logic [1:0] ph_r = 2'h0;
  initial tready = 1'b0;
  // Ready drops one cycle in four so bytes must hold
  always @(posedge aclk) begin
    ph_r <= aresetn ? ph_r + 2'h1 : 2'h0;
    tready <= aresetn && ph_r != 2'h2;
    if (tvalid && tready)
      q.push_back({tlast, tdata});
  end
endmodule

//--- sim/mfa_frame_asm_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module mfa_frame_asm_tb;
  import mfa_pkg::*;
  logic        aclk = 0, aresetn = 0, mv = 0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, tdata;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 32'h0, rd, rdata;
  logic [1:0]  rsp, bresp, rresp, scnt;
  logic        awready, wready, bvalid, arready, rvalid, tvalid, tlast;
  logic        tready, vkind, sv;
  logic [8:0]  vaddr;
  logic [17:0] sw0, sw1;
  logic [31:0] ts = 32'h0A0B0C0D, i0 = 32'h3A1, d0 = 32'h11223344;
  logic [31:0] i1 = 32'h2B2, d1 = 32'h55667788, st = 32'h18001;
  logic [31:0] df = 32'hFFFFFF00;
  logic [31:0] vq[$];
  logic [16:0] ex = 17'h1ABCD;
  logic [9:0]  tp = 10'h39C;
  logic [15:0] vda, vdb;
  // Samples follow the pixel index so order errors show up
  assign vda = {7'h00, vaddr};
  assign vdb = {7'h40, vaddr};
  int          fails = 0, compares = 0, nser = 0;
  always #5 aclk = ~aclk;
  always @(posedge aclk) if (sv) nser++;
  mfa_frame_asm u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .meas_valid(mv), .meas_expo(ex),
    .meas_ts(ts), .meas_temp(tp), .meas_int0(i0),
    .meas_disp0(d0), .meas_int1(i1),
    .meas_disp1(d1), .meas_status(st),
    .meas_trig(32'h80010002), .meas_diff(df),
    .meas_min(32'h1), .meas_max(32'h2), .meas_span(32'h3),
    .vid_addr(vaddr), .vid_kind(vkind), .vid_data_a(vda),
    .vid_data_b(vdb), .net_tvalid(tvalid), .net_tdata(tdata),
    .net_tlast(tlast), .net_tready(tready), .ser_valid(sv),
    .ser_count(scnt), .ser_word0(sw0), .ser_word1(sw1));
  mfa_host_model u_host (.aclk(aclk), .aresetn(aresetn), .tvalid(tvalid),
    .tdata(tdata), .tlast(tlast), .tready(tready));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic meas;
    @(posedge aclk);
    mv <= 1'b1;
    @(posedge aclk);
    mv <= 1'b0;
  endtask
  // Waits for a whole frame, then checks bytes and end marker
  task automatic frame(input logic [31:0] w[$]);
    int n;
    n = 0;
    while (u_host.q.size() < 4 * w.size() && n < 8000) begin
      @(posedge aclk);
      n++;
    end
    repeat (10) @(posedge aclk);
    `CHK(u_host.q.size(), 4 * w.size())
    foreach (w[i]) for (int b = 0; b < 4; b++)
      `CHK(u_host.q[4*i+b], {(i == w.size()-1 && b == 3), w[i][8*b+:8]})
    u_host.q.delete();
  endtask
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd_reg(OFS_SEL);
    `CHK(rd, 32'h0000004C)
    rd_reg(8'h20);
    `CHK(rsp, RESP_SLVERR)
    wr(8'h20, 32'h1);
    `CHK(rsp, RESP_SLVERR)
    $display("registers done");
    meas();
    frame('{32'h0001ABCD, 32'h0, 32'h11223344});
    $display("default frame done");
    wr(OFS_CTRL, 32'h6);
    wr(OFS_SEL, 32'h2FC);
    meas();
    frame('{32'h0001ABCD, 32'h1, 32'h0A0B0C0D, 32'hFFFFFF9C, 32'h3A1,
      32'h11223344, 32'h2B2, 32'h55667788, 32'h18001,
      32'hFFFFFF00});
    $display("thickness frame done");
    wr(OFS_CTRL, 32'h8);
    `CHK(vkind, 1'b1)
    wr(OFS_SEL, 32'h1C0B);
    for (int p = 0; p < 512; p++)
      vq.push_back({7'h40, 9'(p), 7'h00, 9'(p)});
    vq.push_back(32'h2);
    vq.push_back(32'h1);
    vq.push_back(32'h2);
    vq.push_back(32'h3);
    meas();
    // Second cycle lands while the video frame is busy
    meas();
    frame(vq);
    rd_reg(OFS_DROP);
    `CHK(rd, 32'h00000001)
    $display("video frame done");
    wr(OFS_CTRL, 32'h1);
    wr(OFS_SERSEL, 32'h12);
    meas();
    repeat (10) @(posedge aclk);
    `CHK(nser, 1)
    `CHK(scnt, 2'h2)
    `CHK(sw0, 18'h3)
    `CHK(sw1, 18'h1ABCD)
    `CHK(u_host.q.size(), 0)
    wr(OFS_SERSEL, 32'h31);
    meas();
    repeat (10) @(posedge aclk);
    `CHK(nser, 2)
    `CHK(sw0, 18'h1ABCD)
    `CHK(sw1, 18'h20B0C)
    rd_reg(OFS_STAT);
    `CHK(rd[23:0], 24'h5)
    $display("serial done");
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    end_of_test();
  end
endmodule
